// >>> core/actc_pkg.sv
// constants and types of the conversion timing control block
package actc_pkg;
  localparam int         ACTC_DW       = 16;
  localparam logic [7:0] ACTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACTC_STAT_OFS = 8'h04;
  // control register fields
  localparam int         F_SRC    = 0;
  localparam int         F_SRC_W  = 5;
  localparam int         F_ORIGIN = 5;
  localparam int         F_DIV2   = 6;
  localparam int         F_CWIDTH = 7;
  localparam int         F_FOLLOW = 8;
  localparam int         F_LWIDTH = 9;
  localparam int         F_OVRWIN = 10;
  localparam int         F_ERREN  = 11;
  localparam int         CTRL_W   = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  // status register fields
  localparam int         S_OVR  = 0;
  localparam int         S_CONV = 1;
  localparam int         S_LOAD = 2;
  localparam int         S_BUSY = 3;
  localparam int         S_CNT  = 4;
  // conversion source codes
  localparam logic [4:0] SRC_SI2    = 5'h00;
  localparam logic [4:0] SRC_PFI_LO = 5'h01;
  localparam logic [4:0] SRC_PFI_HI = 5'h0a;
  localparam logic [4:0] SRC_TRG_LO = 5'h0b;
  localparam logic [4:0] SRC_TRG_HI = 5'h11;
  localparam logic [4:0] SRC_CTR0   = 5'h13;
  // synchroniser bit positions
  localparam int         SY_EOC  = 0;
  localparam int         SY_SOC  = 1;
  localparam int         SY_PFI  = 2;
  localparam int         SY_TRG  = 12;
  localparam int         SY_SI2  = 19;
  localparam int         SY_CTR0 = 20;
  localparam int         SY_W    = 21;
  // timebase edge counts and buffer depth
  localparam logic [2:0] CONV_EDGES_1 = 3'h2;
  localparam logic [2:0] CONV_EDGES_2 = 3'h4;
  localparam logic [1:0] LOAD_RISES_1 = 2'h1;
  localparam logic [1:0] LOAD_RISES_2 = 2'h2;
  localparam logic [1:0] ACTC_DEPTH   = 2'h2;
  typedef enum logic [0:0] {ACTC_CV_IDLE, ACTC_CV_PULSE} actc_conv_t;
  typedef enum logic [1:0] {ACTC_LD_IDLE, ACTC_LD_FALL,
                            ACTC_LD_RISE} actc_load_t;
endpackage

// >>> core/actc_top.sv
// conversion timing control with wishbone registers and load buffer
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module actc_top
  import actc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               local_oscillator_input,
  input  wire logic               shared_bus_oscillator_input,
  input  wire logic               second_interval_terminal_count,
  input  wire logic [9:0]         programmable_function_input,
  input  wire logic [6:0]         shared_trigger_line,
  input  wire logic               counter0_output,
  input  wire logic               conv_started,
  input  wire logic               conv_done,
  input  wire logic [ACTC_DW-1:0] adc_data,
  output logic                    output_timebase_source,
  output logic                    conv_pulse,
  output logic                    data_load_strobe,
  output logic      [ACTC_DW-1:0] load_data,
  output logic                    load_valid,
  input  wire logic               load_ready,
  output logic                    err_req
);

  typedef struct packed {
    logic [SY_W-1:0]    s1;
    logic [SY_W-1:0]    s2;
    logic               osc_prev;
    logic               tb;
    logic               src_prev;
    logic               eoc_prev;
    logic               soc_prev;
    actc_conv_t         cv;
    logic [2:0]         cedge;
    logic               conv;
    actc_load_t         ld;
    logic [1:0]         lrise;
    logic               load;
    logic               win_a;
    logic               win_b;
    logic               busy;
    logic               ovr;
    logic [CTRL_W-1:0]  ctrl;
    logic [1:0]         cnt;
    logic [ACTC_DW-1:0] head;
    logic [ACTC_DW-1:0] tail;
    logic               ack;
    logic [31:0]        rdat;
  } actc_state_t;

  actc_state_t r_reg;
  actc_state_t r_next;

  function automatic logic rise(input logic p, input logic c);
    return c & ~p;
  endfunction

  function automatic logic pick_src(input logic [4:0] sel,
                                    input logic [SY_W-1:0] s);
    logic [4:0] i;
    i = 5'h00;
    pick_src = 1'b0;
    if (sel == SRC_SI2) begin
      pick_src = ~s[SY_SI2];
    end else if (sel >= SRC_PFI_LO && sel <= SRC_PFI_HI) begin
      i = sel - SRC_PFI_LO;
      pick_src = s[SY_PFI + int'(i)];
    end else if (sel >= SRC_TRG_LO && sel <= SRC_TRG_HI) begin
      i = sel - SRC_TRG_LO;
      pick_src = s[SY_TRG + int'(i)];
    end else if (sel == SRC_CTR0) begin
      pick_src = s[SY_CTR0];
    end
  endfunction

  logic [SY_W-1:0] sync_in;
  logic            osc_sel;
  logic            osc_rise;
  logic            tb_nx;
  logic            tb_rise;
  logic            tb_fall;
  logic            src_lvl;
  logic            src_rise;
  logic            eoc_rise;
  logic            soc_rise;
  logic            window;
  logic            room;
  logic            conv_go;
  logic            follow;
  logic [2:0]      c_target;
  logic [1:0]      l_target;
  logic            req;
  logic            clr_ovr;
  logic            push;
  logic            pop;
  logic [31:0]     stat;

  assign sync_in = {counter0_output, second_interval_terminal_count,
                    shared_trigger_line, programmable_function_input,
                    conv_started, conv_done};
  assign follow   = r_reg.ctrl[F_FOLLOW];
  assign osc_sel  = r_reg.ctrl[F_ORIGIN] ? shared_bus_oscillator_input
                                         : local_oscillator_input;
  assign osc_rise = rise(r_reg.osc_prev, osc_sel);
  assign tb_nx    = r_reg.ctrl[F_DIV2] ? (r_reg.tb ^ osc_rise)
                                       : osc_sel;
  assign tb_rise  = rise(r_reg.tb, tb_nx);
  assign tb_fall  = rise(tb_nx, r_reg.tb);
  assign src_lvl  = pick_src(r_reg.ctrl[F_SRC +: F_SRC_W], r_reg.s2);
  assign src_rise = rise(r_reg.src_prev, src_lvl);
  assign eoc_rise = rise(r_reg.eoc_prev, r_reg.s2[SY_EOC]);
  assign soc_rise = rise(r_reg.soc_prev, r_reg.s2[SY_SOC]);
  assign window   = r_reg.win_a
                  | (r_reg.ctrl[F_OVRWIN] & r_reg.win_b);
  // a conversion in flight reserves its buffer slot
  assign room     = (r_reg.cnt + {1'b0, r_reg.win_a | r_reg.win_b})
                    < ACTC_DEPTH;
  assign conv_go  = src_rise & room & ~r_reg.conv;
  assign c_target = r_reg.ctrl[F_CWIDTH] ? CONV_EDGES_2
                                         : CONV_EDGES_1;
  assign l_target = r_reg.ctrl[F_LWIDTH] ? LOAD_RISES_2 : LOAD_RISES_1;
  assign req      = wb_cyc_i & wb_stb_i & ~r_reg.ack;
  assign clr_ovr  = req & wb_we_i & (wb_adr_i == ACTC_STAT_OFS)
                  & wb_sel_i[0] & wb_dat_i[S_OVR];
  assign pop      = load_valid & load_ready;
  assign push     = (r_reg.ld == ACTC_LD_RISE) & tb_rise
                  & (r_reg.lrise + 2'h1 == l_target);

  always_comb begin
    stat = 32'h0000_0000;
    stat[S_OVR] = r_reg.ovr;
    stat[S_CONV] = r_reg.conv;
    stat[S_LOAD] = r_reg.load;
    stat[S_BUSY] = r_reg.busy;
    stat[S_CNT +: 2] = r_reg.cnt;
  end
  always_comb begin
    r_next = r_reg;
    r_next.s1 = sync_in;
    r_next.s2 = r_reg.s1;
    r_next.osc_prev = osc_sel;
    r_next.tb = tb_nx;
    r_next.src_prev = src_lvl;
    r_next.eoc_prev = r_reg.s2[SY_EOC];
    r_next.soc_prev = r_reg.s2[SY_SOC];
    r_next.busy = soc_rise | (r_reg.busy & ~eoc_rise);
    // conversion pulse
    if (follow) begin
      r_next.cv = ACTC_CV_IDLE;
      r_next.conv = src_lvl & (r_reg.conv | conv_go);
    end else begin
      case (r_reg.cv)
        ACTC_CV_IDLE: begin
          r_next.conv = 1'b0;
          if (conv_go) begin
            r_next.cv = ACTC_CV_PULSE;
            r_next.cedge = 3'h0;
            r_next.conv = 1'b1;
          end
        end
        ACTC_CV_PULSE: begin
          if (tb_rise | tb_fall) begin
            r_next.cedge = r_reg.cedge + 3'h1;
            if (r_reg.cedge + 3'h1 == c_target) begin
              r_next.cv = ACTC_CV_IDLE;
              r_next.conv = 1'b0;
            end
          end
        end
        default: begin
          r_next.cv = ACTC_CV_IDLE;
          r_next.conv = 1'b0;
        end
      endcase
    end
    // load strobe
    case (r_reg.ld)
      ACTC_LD_IDLE: begin
        if (eoc_rise) begin
          r_next.ld = ACTC_LD_FALL;
          r_next.load = 1'b1;
          r_next.win_a = 1'b0;
          r_next.win_b = 1'b1;
        end
      end
      ACTC_LD_FALL: begin
        if (tb_fall) begin
          r_next.ld = ACTC_LD_RISE;
          r_next.lrise = 2'h0;
        end
      end
      ACTC_LD_RISE: begin
        if (tb_rise) begin
          r_next.lrise = r_reg.lrise + 2'h1;
          if (push) begin
            r_next.ld = ACTC_LD_IDLE;
            r_next.load = 1'b0;
            r_next.win_b = 1'b0;
          end
        end
      end
      default: begin
        r_next.ld = ACTC_LD_IDLE;
        r_next.load = 1'b0;
      end
    endcase
    if (conv_go) begin
      r_next.win_a = 1'b1;
    end
    // set wins over a simultaneous clear
    r_next.ovr = (r_reg.ovr & ~clr_ovr) | (src_rise & window);
    // two-entry buffer; word taken at the strobe's trailing edge
    case ({push, pop})
      2'b10: begin
        if (r_reg.cnt == 2'h0) begin
          r_next.head = adc_data;
        end else begin
          r_next.tail = adc_data;
        end
        r_next.cnt = r_reg.cnt + 2'h1;
      end
      2'b01: begin
        r_next.head = r_reg.tail;
        r_next.cnt = r_reg.cnt - 2'h1;
      end
      2'b11: begin
        if (r_reg.cnt == 2'h1) begin
          r_next.head = adc_data;
        end else begin
          r_next.head = r_reg.tail;
          r_next.tail = adc_data;
        end
      end
      default: begin
      end
    endcase
    // wishbone slave, unmapped reads return zero
    r_next.ack = req;
    if (req && wb_we_i && wb_adr_i == ACTC_CTRL_OFS) begin
      if (wb_sel_i[0]) begin
        r_next.ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        r_next.ctrl[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
      end
    end
    if (req && !wb_we_i) begin
      if (wb_adr_i == ACTC_CTRL_OFS) begin
        r_next.rdat = {{(32-CTRL_W){1'b0}}, r_reg.ctrl};
      end else if (wb_adr_i == ACTC_STAT_OFS) begin
        r_next.rdat = stat;
      end else begin
        r_next.rdat = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.ctrl <= CTRL_RST;
      r_reg.src_prev <= 1'b1; // no false source edge after reset
    end else begin
      r_reg <= r_next;
    end
  end
  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rdat;
  assign output_timebase_source = r_reg.tb;
  assign conv_pulse = r_reg.conv;
  assign data_load_strobe = r_reg.load;
  assign load_data = r_reg.head;
  assign load_valid = r_reg.cnt != 2'h0;
  assign err_req = r_reg.ovr & r_reg.ctrl[F_ERREN];

  src_pick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    r_reg.ctrl[F_SRC +: F_SRC_W] == SRC_CTR0
      |-> src_lvl == r_reg.s2[SY_CTR0])
    else $error("source select does not follow counter 0");
  tb_origin_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !r_reg.ctrl[F_DIV2] && $stable(r_reg.ctrl)
      |-> r_reg.tb == $past(osc_sel))
    else $error("timebase does not follow selected oscillator");
  tb_div_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    r_reg.ctrl[F_DIV2] && $past(r_reg.ctrl[F_DIV2]) && $changed(r_reg.tb)
      |-> $past(osc_rise))
    else $error("divided timebase moved without oscillator rise");
  conv_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(r_reg.conv) && $past(r_reg.cv == ACTC_CV_PULSE)
      |-> $past(r_reg.cedge + 3'h1 == c_target) && $past(tb_rise | tb_fall))
    else $error("conversion pulse width wrong");
  conv_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    follow && $past(follow) && r_reg.conv |-> $past(src_lvl))
    else $error("followed pulse outlives its source");
  load_start_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    eoc_rise && r_reg.ld == ACTC_LD_IDLE |=> r_reg.load ##1 r_reg.load)
    else $error("load strobe missed conversion done");
  load_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(r_reg.load) |-> $past(tb_rise) && $past(r_reg.ld == ACTC_LD_RISE))
    else $error("load strobe ended off a rising edge");
  ovr_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    src_rise && window |=> r_reg.ovr)
    else $error("overrun in window not flagged");
  ovr_win_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    src_rise && !r_reg.win_a && !r_reg.ctrl[F_OVRWIN] && !r_reg.ovr
      |=> !r_reg.ovr)
    else $error("overrun flagged outside interval A");
  conv_room_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(r_reg.conv) |-> $past(room) && $past(src_rise))
    else $error("conversion started without buffer room");
  sync_two_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(resetn, 2) |-> r_reg.s2 == $past(sync_in, 2))
    else $error("synchroniser depth is not two");

endmodule

// >>> bench/actc_adc_model.sv
// converter model answering each conversion pulse
`timescale 1ns/1ps
module actc_adc_model
  import actc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               slow,
  input  wire logic               conv_pulse,
  input  wire logic               data_load_strobe,
  output logic                    conv_started,
  output logic                    conv_done,
  output logic      [ACTC_DW-1:0] adc_data
);
  int unsigned        t    = 0;
  int unsigned        dn;
  logic [ACTC_DW-1:0] n    = '0;
  logic               cp_q = 1'b0;
  logic               ls_q = 1'b0;
  assign dn = slow ? 30 : 8;
  assign conv_started = (t == 2) || (t == 3);
  assign conv_done = (t == dn) || (t == dn + 1);
  initial adc_data = '0;
  always @(posedge clk_sys) begin
    cp_q <= conv_pulse;
    ls_q <= data_load_strobe;
    if (conv_pulse && !cp_q) begin
      t <= 1;
    end else if (t != 0 && t < 99) begin
      t <= t + 1;
    end
    // a restarted conversion yields one result, so count results
    if (t == dn) begin
      n <= n + 1'b1;
      adc_data <= 16'h1001 + n;
    end else if ((conv_pulse && !cp_q) || (ls_q && !data_load_strobe)) begin
      // garbage while converting and after the strobe trailing edge
      adc_data <= ~adc_data;
    end
  end
endmodule

// >>> bench/test_adc_conversion_timing_control.sv
// self-checking bench of the conversion timing control block
`timescale 1ns/1ps
module test_adc_conversion_timing_control;
  import actc_pkg::*;
  logic               clk_sys = 1'b0;
  logic               resetn = 1'b0;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [7:0]         wb_adr_i = 8'h00;
  logic [3:0]         wb_sel_i = 4'h0;
  logic [31:0]        wb_dat_i = 32'h0;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic               local_oscillator_input = 1'b0;
  logic               shared_bus_oscillator_input = 1'b0;
  logic               second_interval_terminal_count = 1'b1;
  logic [9:0]         programmable_function_input = 10'h000;
  logic [6:0]         shared_trigger_line = 7'h00;
  logic               counter0_output = 1'b0;
  logic               conv_started;
  logic               conv_done;
  logic [ACTC_DW-1:0] adc_data;
  logic               output_timebase_source;
  logic               conv_pulse;
  logic               data_load_strobe;
  logic [ACTC_DW-1:0] load_data;
  logic               load_valid;
  logic               load_ready = 1'b1;
  logic               err_req;
  logic               slow = 1'b0;
  logic               tb_q = 1'b0;
  logic [2:0]         ph = 3'h0;
  logic [15:0]        exp_word = 16'h1001;
  logic [31:0]        q;
  int                 fails = 0;
  int                 n_tests = 0;
  int                 cyc_n = 0;
  int                 n_conv = 0;
  int                 n_tog = 0;
  int                 cw = 0;
  int                 cw_last = 0;
  int                 lw = 0;
  int                 lw_last = 0;

  actc_top actc_top_inst (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .local_oscillator_input, .shared_bus_oscillator_input,
    .second_interval_terminal_count, .programmable_function_input,
    .shared_trigger_line, .counter0_output, .conv_started, .conv_done,
    .adc_data, .output_timebase_source, .conv_pulse, .data_load_strobe,
    .load_data, .load_valid, .load_ready, .err_req);
  actc_adc_model actc_adc_model_inst (.clk_sys, .slow, .conv_pulse,
    .data_load_strobe, .conv_started, .conv_done, .adc_data);

  always #12.5 clk_sys = ~clk_sys;

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      fails = fails + 1;
      give_verdict;
    end
  end

  // oscillators, pulse widths, timebase toggles and the word consumer
  always @(posedge clk_sys) begin
    ph <= ph + 3'h1;
    local_oscillator_input <= ph[1];
    shared_bus_oscillator_input <= ph[2];
    cw <= conv_pulse ? cw + 1 : 0;
    if (!conv_pulse && cw != 0) cw_last <= cw;
    if (!conv_pulse && cw != 0) n_conv <= n_conv + 1;
    lw <= data_load_strobe ? lw + 1 : 0;
    if (!data_load_strobe && lw != 0) lw_last <= lw;
    tb_q <= output_timebase_source;
    if (tb_q !== output_timebase_source) n_tog <= n_tog + 1;
    if (load_valid === 1'b1 && load_ready) begin
      n_tests++;
      if (load_data !== exp_word) begin
        fails++;
        $display("BAD load_data expected %h seen %h", exp_word, load_data);
      end
      exp_word <= exp_word + 16'h1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic src(input logic [4:0] c, input logic v);
    case (c)
      SRC_SI2: second_interval_terminal_count <= ~v;
      SRC_CTR0, 5'h12: counter0_output <= v;
      default:
        if (c <= SRC_PFI_HI) programmable_function_input[c - 1] <= v;
        else shared_trigger_line[c - 11] <= v;
    endcase
  endtask

  // aligned to the oscillator phase so widths repeat exactly
  task automatic fire(input logic [4:0] c, input int hold, input int gap);
    do @(posedge clk_sys); while (ph != 3'h0);
    src(c, 1'b1);
    tick(hold);
    src(c, 1'b0);
    tick(gap);
  endtask

  task automatic t_regs;
    wb(1'b0, ACTC_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'(CTRL_RST), q);
    wb(1'b1, ACTC_CTRL_OFS, 32'hffff_ffff);
    wb(1'b1, 8'h40, 32'h0);
    wb(1'b0, ACTC_CTRL_OFS, 32'h0);
    chk("ctrl readback", 32'h0000_0fff, q);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, ACTC_CTRL_OFS, 32'h0);
    $display("regs test done");
  endtask

  task automatic t_sources;
    logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h0a, 5'h0b, 5'h11, 5'h13,
                              5'h12};
    int k;
    foreach (codes[i]) begin
      wb(1'b1, ACTC_CTRL_OFS, 32'(codes[i]));
      k = n_conv;
      fire(codes[i], 3, 70);
      chk("conversions", (codes[i] == 5'h12) ? k : k + 1, n_conv);
    end
    $display("sources test done");
  endtask

  task automatic t_width;
    int a;
    int b;
    wb(1'b1, ACTC_CTRL_OFS, 32'h1);
    fire(5'h01, 3, 70);
    a = cw_last;
    b = lw_last;
    chk("conv width short", 1, a >= 3 && a <= 5);
    wb(1'b1, ACTC_CTRL_OFS, 32'h1 | 32'h1 << F_CWIDTH | 32'h1 << F_LWIDTH);
    fire(5'h01, 3, 70);
    chk("conv width step", 1, cw_last - a >= 3 && cw_last - a <= 5);
    chk("strobe width step", 1, lw_last - b >= 3 && lw_last - b <= 5);
    wb(1'b1, ACTC_CTRL_OFS, 32'h1 | 32'h1 << F_FOLLOW);
    fire(5'h01, 12, 70);
    chk("follow width", 1, cw_last >= 11 && cw_last <= 13);
    $display("width test done");
  endtask

  task automatic t_timebase;
    int k;
    int e;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ACTC_CTRL_OFS, 32'(i) << F_ORIGIN);
      tick(8);
      k = n_tog;
      e = 32 >> (i % 2 + i / 2);
      tick(64);
      chk("timebase toggles", 1, n_tog - k >= e - 2 && n_tog - k <= e + 2);
    end
    $display("timebase test done");
  endtask

  task automatic t_overrun;
    int k;
    slow <= 1'b1;
    wb(1'b1, ACTC_CTRL_OFS, 32'h1 | 32'h1 << F_OVRWIN | 32'h1 << F_ERREN);
    k = n_conv;
    fire(5'h01, 3, 12);
    fire(5'h01, 3, 90);
    // the second pulse still fires, inside the window
    chk("overrun conversions", k + 2, n_conv);
    wb(1'b0, ACTC_STAT_OFS, 32'h0);
    chk("overrun flag", 32'h1, q & 32'h1);
    chk("error request", 32'h1, 32'(err_req));
    wb(1'b1, ACTC_STAT_OFS, 32'h1);
    wb(1'b0, ACTC_STAT_OFS, 32'h0);
    chk("flag cleared", 32'h0, q & 32'h1);
    chk("request cleared", 32'h0, 32'(err_req));
    slow <= 1'b0;
    $display("overrun test done");
  endtask

  task automatic t_buffer;
    int k;
    wb(1'b1, ACTC_CTRL_OFS, 32'h1);
    load_ready <= 1'b0;
    k = n_conv;
    repeat (3) fire(5'h01, 3, 70);
    chk("held back", k + 2, n_conv);
    wb(1'b0, ACTC_STAT_OFS, 32'h0);
    chk("buffer full", 32'h20, q & 32'h31);
    load_ready <= 1'b1;
    tick(10);
    chk("drained", 32'h0, 32'(load_valid));
    $display("buffer test done");
  endtask

  initial begin
    tick(3);
    resetn <= 1'b1;
    t_regs;
    t_sources;
    t_width;
    t_timebase;
    t_overrun;
    t_buffer;
    // the overrun pulse restarted the converter, so the first pulse gave no word
    chk("words paired", 32'(16'h1001 + n_conv - 1), 32'(exp_word));
    give_verdict;
  end
endmodule
